/* hw/tbpc_chan_b.sv */
// Purpose: B general register and B pin logic of one channel
// Assumes: Field is bits 7:4 of the channel I/O control register
// Notes: Events are one-cycle pulses qualified by the caller
`default_nettype none

module tbpc_chan_b
	import tbpc_pkg::*;
#(
	parameter int CH = 1,
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic [3:0] field,
	input wire logic [CNT_W-1:0] count,
	input wire logic pin_in,
	input wire logic int_evt,
	input wire logic gr_wr,
	input wire logic [CNT_W-1:0] gr_wdata,
	output logic [CNT_W-1:0] gr_b,
	output logic pin_out,
	output logic pin_oe_n,
	output logic cmp_evt,
	output logic cap_evt
);

	generate if (CH < 1 || CH > NUM_CH || CNT_W < 2 || CNT_W > 32) begin : g_bad
		$error("tbpc_chan_b: unsupported CH or CNT_W");
	end endgenerate

	function automatic logic drives_pin(input logic [3:0] f);
		return !f[FB_MODE] && (f[1:0] != ACT_KEEP);
	endfunction

	logic [CNT_W-1:0] gr_r, gr_nxt;
	logic [3:0] fld_r, fld_nxt;
	logic pin_r, pin_nxt, oe_n_r, oe_n_nxt, prev_r, prev_nxt;
	logic rise, fall, sel_new, out_en, use_int, edge_hit, cap_hit, cmp_hit;

	//==========================================================
	// Next state
	always_comb begin
		rise = pin_in && !prev_r;
		fall = !pin_in && prev_r;
		sel_new = field != fld_r;
		out_en = drives_pin(field); // R01
		use_int = field[FB_MODE] && field[FB_INIT] && (CH != 2); // R09 R10 R11
		edge_hit = field[1] ? (rise || fall) : (field[0] ? fall : rise); // R06 R07 R08
		cap_hit = field[FB_MODE] && (use_int ? int_evt : edge_hit); // R13
		cmp_hit = !field[FB_MODE] && (count == gr_r); // R14
		prev_nxt = pin_in;
		fld_nxt = field;
		oe_n_nxt = !out_en;
		pin_nxt = pin_r;
		if (sel_new && out_en) begin
			pin_nxt = field[FB_INIT]; // R01 R02
		end else if (cmp_hit && out_en) begin
			case (field[1:0])
				ACT_LOW: pin_nxt = 1'b0; // R03
				ACT_HIGH: pin_nxt = 1'b1; // R04
				ACT_TOGGLE: pin_nxt = !pin_r; // R05
				default: pin_nxt = pin_r;
			endcase
		end
		gr_nxt = gr_r;
		if (cap_hit) begin
			gr_nxt = count; // R06
		end else if (gr_wr) begin
			gr_nxt = gr_wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gr_r <= {CNT_W{GRB_RESET_BIT}};
			fld_r <= IOC_RESET[FLD_MSB:FLD_LSB];
			pin_r <= PIN_RESET;
			oe_n_r <= PIN_OE_N_RESET;
			prev_r <= PIN_RESET;
		end else if (clk_en) begin
			gr_r <= gr_nxt;
			fld_r <= fld_nxt;
			pin_r <= pin_nxt;
			oe_n_r <= oe_n_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign gr_b = gr_r;
	assign pin_out = pin_r;
	assign pin_oe_n = oe_n_r;
	assign cmp_evt = cmp_hit;
	assign cap_evt = cap_hit;

	//==========================================================
	// Checks
	sequence s_sel_drive;
		clk_en && sel_new && out_en;
	endsequence

	sequence s_match(logic [1:0] act);
		clk_en && !sel_new && !field[FB_MODE] && count == gr_r && field[1:0] == act;
	endsequence

	sequence s_quiet_cap;
		clk_en && field[FB_MODE] && !rise && !fall && !gr_wr;
	endsequence

	a_pin_off: assert property (@(posedge hclk) disable iff (!hresetn) // R01
		clk_en && !field[FB_MODE] && field[1:0] == ACT_KEEP |=> pin_oe_n)
		else $error("pin driven with output disabled");
	a_init_level: assert property (@(posedge hclk) disable iff (!hresetn) // R02
		s_sel_drive |=> !pin_oe_n && pin_out == $past(field[FB_INIT]))
		else $error("initial level wrong");
	a_match_low: assert property (@(posedge hclk) disable iff (!hresetn) // R03
		s_match(ACT_LOW) |=> !pin_out)
		else $error("pin not low after match");
	a_match_high: assert property (@(posedge hclk) disable iff (!hresetn) // R04
		s_match(ACT_HIGH) |=> pin_out)
		else $error("pin not high after match");
	a_match_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // R05
		s_match(ACT_TOGGLE) |=> pin_out != $past(pin_out))
		else $error("pin not toggled after match");
	a_cap_rise: assert property (@(posedge hclk) disable iff (!hresetn) // R06
		clk_en && field == 4'h8 && rise |=> gr_b == $past(count))
		else $error("no capture at rising edge");
	a_cap_fall: assert property (@(posedge hclk) disable iff (!hresetn) // R07
		clk_en && field == 4'h9 && fall |=> gr_b == $past(count))
		else $error("no capture at falling edge");
	a_cap_both: assert property (@(posedge hclk) disable iff (!hresetn) // R08
		clk_en && field[3:1] == 3'h5 && (rise || fall) |=> gr_b == $past(count))
		else $error("no capture at pin edge");
	a_cap_internal: assert property (@(posedge hclk) disable iff (!hresetn) // R09
		CH != 2 && clk_en && field[3:2] == 2'h3 && int_evt |=> gr_b == $past(count))
		else $error("no capture on internal source");
	a_ch2_pin_only: assert property (@(posedge hclk) disable iff (!hresetn) // R10
		(CH == 2) and s_quiet_cap |=> gr_b == $past(gr_b))
		else $error("channel 2 captured without pin edge");
	a_own_pin: assert property (@(posedge hclk) disable iff (!hresetn) // R13
		(field[FB_INIT] == 1'b0) and s_quiet_cap |=> gr_b == $past(gr_b))
		else $error("pin source captured without edge");

endmodule

`default_nettype wire

/* hw/tbpc_io_ctrl.sv */
// Purpose: Timer B pin I/O control for channels 1 to 3, AHB-Lite slave
// Assumes: Pins and counters synchronous to hclk
// Notes: Reads take one wait state, writes none
`default_nettype none

module tbpc_io_ctrl
	import tbpc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [CNT_W-1:0] ch1_count,
	input wire logic [CNT_W-1:0] ch2_count,
	input wire logic [CNT_W-1:0] ch3_count,
	input wire logic ch1_pin_b_in,
	output logic ch1_pin_b_out,
	output logic ch1_pin_b_oe_n,
	input wire logic ch2_pin_b_in,
	output logic ch2_pin_b_out,
	output logic ch2_pin_b_oe_n,
	input wire logic ch3_pin_b_in,
	output logic ch3_pin_b_out,
	output logic ch3_pin_b_oe_n,
	input wire logic ch0_general_reg_c_event,
	input wire logic ch4_counter_step,
	input wire logic [2:0] ch4_prescaler_select,
	output logic irq
);

	generate if (CNT_W < 2 || CNT_W > 32) begin : g_bad
		$error("tbpc_io_ctrl: CNT_W must be 2 to 32");
	end endgenerate

	//==========================================================
	// Address decode
	function automatic tbpc_sel_e reg_decode(input logic [7:0] a);
		tbpc_sel_e s;
		s = SEL_NONE;
		case (a)
			OFS_IOC1: s = SEL_IOC1;
			OFS_IOC2: s = SEL_IOC2;
			OFS_IOC3: s = SEL_IOC3;
			OFS_GRB1: s = SEL_GRB1;
			OFS_GRB2: s = SEL_GRB2;
			OFS_GRB3: s = SEL_GRB3;
			OFS_STAT: s = SEL_STAT;
			OFS_CLR: s = SEL_CLR;
			OFS_IEN: s = SEL_IEN;
			OFS_PINS: s = SEL_PINS;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	//==========================================================
	// Declarations
	tbpc_bus_e bus_r, bus_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic take, wr_act;
	tbpc_sel_e wr_sel, rd_sel;

	logic [7:0] ioc_r [NUM_CH];
	logic [7:0] ioc_nxt [NUM_CH];
	logic [7:0] ien_r, ien_nxt;
	logic [7:0] status_r, status_nxt;
	logic [7:0] clr_mask, evt_mask;
	logic [NUM_CH-1:0] gr_wr;

	logic [CNT_W-1:0] count_a [NUM_CH];
	logic [CNT_W-1:0] grb [NUM_CH];
	logic [NUM_CH-1:0] pin_in_a, pin_out_a, pin_oe_n_a;
	logic [NUM_CH-1:0] int_evt, cmp_evt, cap_evt;
	logic ch4_clock_ok;

	//==========================================================
	// Bus slave
	assign take = hsel && hready && htrans[1] && clk_en;
	assign wr_act = clk_en && (bus_r == BUS_WR);
	assign wr_sel = reg_decode(addr_r);
	assign rd_sel = reg_decode(addr_r);

	always_comb begin
		bus_nxt = bus_r;
		addr_nxt = addr_r;
		rdata_nxt = rdata_r;
		case (bus_r)
			BUS_IDLE, BUS_WR, BUS_RD_DONE: begin
				if (take) begin
					addr_nxt = haddr[7:0];
					bus_nxt = hwrite ? BUS_WR : BUS_RD_WAIT;
				end else begin
					bus_nxt = BUS_IDLE;
				end
			end
			BUS_RD_WAIT: begin
				bus_nxt = BUS_RD_DONE;
				case (rd_sel)
					SEL_IOC1: rdata_nxt = 32'(ioc_r[0]);
					SEL_IOC2: rdata_nxt = 32'(ioc_r[1]);
					SEL_IOC3: rdata_nxt = 32'(ioc_r[2]);
					SEL_GRB1: rdata_nxt = 32'(grb[0]);
					SEL_GRB2: rdata_nxt = 32'(grb[1]);
					SEL_GRB3: rdata_nxt = 32'(grb[2]);
					SEL_STAT: rdata_nxt = 32'(status_r);
					SEL_IEN: rdata_nxt = 32'(ien_r);
					SEL_PINS: begin
						rdata_nxt = 32'h0000_0000;
						rdata_nxt[PINS_IN_LSB +: NUM_CH] = pin_in_a;
						rdata_nxt[NUM_CH-1:0] = pin_out_a;
					end
					default: rdata_nxt = 32'h0000_0000;
				endcase
			end
			default: bus_nxt = BUS_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_r <= BUS_IDLE;
			addr_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			bus_r <= bus_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign hreadyout = clk_en && (bus_r != BUS_RD_WAIT);
	assign hresp = 1'b0;
	assign hrdata = rdata_r;

	//==========================================================
	// Register writes
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			ioc_nxt[i] = ioc_r[i];
		end
		ien_nxt = ien_r;
		clr_mask = 8'h00;
		gr_wr = '0;
		if (wr_act) begin
			case (wr_sel)
				SEL_IOC1: ioc_nxt[0] = hwdata[7:0];
				SEL_IOC2: ioc_nxt[1] = hwdata[7:0];
				SEL_IOC3: ioc_nxt[2] = hwdata[7:0];
				SEL_GRB1: gr_wr[0] = 1'b1;
				SEL_GRB2: gr_wr[1] = 1'b1;
				SEL_GRB3: gr_wr[2] = 1'b1;
				SEL_CLR: clr_mask = hwdata[7:0];
				SEL_IEN: ien_nxt = hwdata[7:0];
				default: clr_mask = 8'h00;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ioc_r[i] <= IOC_RESET;
			end
			ien_r <= IEN_RESET;
		end else if (clk_en) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ioc_r[i] <= ioc_nxt[i];
			end
			ien_r <= ien_nxt;
		end
	end

	//==========================================================
	// Channel units
	assign count_a[0] = ch1_count;
	assign count_a[1] = ch2_count;
	assign count_a[2] = ch3_count;
	assign pin_in_a = {ch3_pin_b_in, ch2_pin_b_in, ch1_pin_b_in};
	assign {ch3_pin_b_out, ch2_pin_b_out, ch1_pin_b_out} = pin_out_a;
	assign {ch3_pin_b_oe_n, ch2_pin_b_oe_n, ch1_pin_b_oe_n} = pin_oe_n_a;

	assign ch4_clock_ok = ch4_prescaler_select != PSC_UNDIVIDED; // R12
	assign int_evt[0] = ch0_general_reg_c_event; // R09
	assign int_evt[1] = 1'b0; // R10
	assign int_evt[2] = ch4_counter_step && ch4_clock_ok; // R11 R12

	generate for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		tbpc_chan_b #(
			.CH(g + 1),
			.CNT_W(CNT_W)
		) u_chan (
			.hclk(hclk),
			.hresetn(hresetn),
			.clk_en(clk_en),
			.field(ioc_r[g][FLD_MSB:FLD_LSB]),
			.count(count_a[g]),
			.pin_in(pin_in_a[g]),
			.int_evt(int_evt[g]),
			.gr_wr(gr_wr[g]),
			.gr_wdata(hwdata[CNT_W-1:0]),
			.gr_b(grb[g]),
			.pin_out(pin_out_a[g]),
			.pin_oe_n(pin_oe_n_a[g]),
			.cmp_evt(cmp_evt[g]),
			.cap_evt(cap_evt[g])
		);
	end endgenerate

	//==========================================================
	// Status and interrupt
	always_comb begin
		evt_mask = 8'h00;
		evt_mask[ST_CMP_LSB +: NUM_CH] = cmp_evt;
		evt_mask[ST_CAP_LSB +: NUM_CH] = cap_evt;
		status_nxt = (status_r & ~clr_mask) | evt_mask;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= STAT_RESET;
		end else if (clk_en) begin
			status_r <= status_nxt;
		end
	end

	assign irq = |(status_r & ien_r);

	//==========================================================
	// Checks
	sequence s_ch3_internal;
		clk_en && ioc_r[2][FLD_MSB:FLD_MSB-1] == 2'h3;
	endsequence

	a_ch3_clock: assert property (@(posedge hclk) disable iff (!hresetn) // R11
		s_ch3_internal and (ch4_clock_ok && ch4_counter_step) |=> status_r[ST_CAP_LSB + 2])
		else $error("channel 3 missed count-clock capture");
	a_ch3_undivided: assert property (@(posedge hclk) disable iff (!hresetn) // R12
		s_ch3_internal and (!ch4_clock_ok) |-> !cap_evt[2])
		else $error("capture with undivided channel 4 clock");
	a_cmp_status: assert property (@(posedge hclk) disable iff (!hresetn) // R14
		clk_en && !ioc_r[0][FLD_MSB] && ch1_count == grb[0] |=> status_r[ST_CMP_LSB])
		else $error("compare match not flagged");
	a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && cap_evt[0] && clr_mask[ST_CAP_LSB] |=> status_r[ST_CAP_LSB])
		else $error("event lost under clear");
	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && (evt_mask & ien_r) != 8'h00 && ien_nxt == ien_r |=> irq)
		else $error("interrupt not raised");
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite |=> !hreadyout)
		else $error("read answered without wait");

endmodule

`default_nettype wire

/* hw/tbpc_pkg.sv */
// Purpose: Constants and types for the timer B pin I/O control block
// Assumes: AHB-Lite word access, hclk at 200 MHz
// Notes: Shared by the top and the per-channel B unit
// Contract
// (R01) Codes 0000/0100 pin off; 0001-0011 start low
// (R02) Codes 0101-0111 compare, pin starts high
// (R03) Compare code x01 drives pin low at match
// (R04) Compare code x10 drives pin high at match
// (R05) Compare code x11 toggles pin at match
// (R06) Code 1000 captures counter at rising edge
// (R07) Code 1001 captures counter at falling edge
// (R08) Code 101x captures counter at both edges
// (R09) Channel 1 11xx captures on channel 0 C event
// (R10) Channel 2 ignores bit 6, pin only
// (R11) Channel 3 11xx captures on channel 4 count
// (R12) Channel 4 undivided clock: no channel 3 capture
// (R13) Channels 1, 3 codes 10xx use own pin
// (R14) Match is counter equal register, acted that cycle
`default_nettype none

package tbpc_pkg;

	//==========================================================
	// Register offsets
	localparam logic [7:0] OFS_IOC1 = 8'h00;
	localparam logic [7:0] OFS_IOC2 = 8'h04;
	localparam logic [7:0] OFS_IOC3 = 8'h08;
	localparam logic [7:0] OFS_GRB1 = 8'h0c;
	localparam logic [7:0] OFS_GRB2 = 8'h10;
	localparam logic [7:0] OFS_GRB3 = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_CLR = 8'h1c;
	localparam logic [7:0] OFS_IEN = 8'h20;
	localparam logic [7:0] OFS_PINS = 8'h24;

	//==========================================================
	// Reset values
	localparam logic [7:0] IOC_RESET = 8'h00;
	localparam logic GRB_RESET_BIT = 1'b1;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] IEN_RESET = 8'h00;
	localparam logic PIN_RESET = 1'b0;
	localparam logic PIN_OE_N_RESET = 1'b1;

	//==========================================================
	// Field layout
	localparam int FLD_LSB = 4;
	localparam int FLD_MSB = 7;
	localparam int FB_MODE = 3;
	localparam int FB_INIT = 2;
	localparam int ST_CMP_LSB = 0;
	localparam int ST_CAP_LSB = 4;
	localparam int PINS_IN_LSB = 4;
	localparam int NUM_CH = 3;
	localparam logic [1:0] ACT_KEEP = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [2:0] PSC_UNDIVIDED = 3'h0;

	//==========================================================
	// Types
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WR = 2'b01,
		BUS_RD_WAIT = 2'b10,
		BUS_RD_DONE = 2'b11
	} tbpc_bus_e;

	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_IOC1 = 4'h1,
		SEL_IOC2 = 4'h2,
		SEL_IOC3 = 4'h3,
		SEL_GRB1 = 4'h4,
		SEL_GRB2 = 4'h5,
		SEL_GRB3 = 4'h6,
		SEL_STAT = 4'h7,
		SEL_CLR = 4'h8,
		SEL_IEN = 4'h9,
		SEL_PINS = 4'ha
	} tbpc_sel_e;

endpackage

`default_nettype wire

/* tb/tbpc_far_model.sv */
// Purpose: Far side of the timer B pin block: counters, pins, neighbour events
// Assumes: Counters of channels 1 to 3 share one run control
// Notes: Channel 4 steps every cycle when undivided, else every fourth cycle
`default_nettype none

module tbpc_far_model
	import tbpc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic [2:0] ld,
	input wire logic [15:0] ld_val,
	input wire logic [2:0] ext_lvl,
	input wire logic c0_req,
	input wire logic [2:0] presc,
	input wire logic [2:0] pout,
	input wire logic [2:0] poe_n,
	output logic [2:0][15:0] cnt,
	output logic [2:0] pin_in,
	output logic c0_evt,
	output logic step
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] pc_r;

	//==========================================================
	// Counters and neighbour events
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			c0_evt <= 1'b0;
			pc_r <= 2'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (ld[i])
					cnt[i] <= ld_val;
				else if (run)
					cnt[i] <= cnt[i] + 16'h0001;
			end
			c0_evt <= c0_req;
			pc_r <= pc_r + 2'h1;
		end
	end

	assign step = (presc == PSC_UNDIVIDED) || (pc_r == 2'h0);

	//==========================================================
	// Pin wire level: device drives when enable is low
	assign pin_in = (ext_lvl & poe_n) | (pout & ~poe_n);

endmodule

`default_nettype wire

/* tb/test_tbpc_io_ctrl.sv */
// Purpose: Self-checking bench for the timer B pin I/O control block
// Assumes: AHB-Lite single word transfers, 200 MHz clock
// Notes: Compare, capture, internal sources and interrupt paths
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module test_tbpc_io_ctrl
	import tbpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic hclk, hresetn, clk_en, hsel, hwrite, run, c0_req;
	logic [31:0] haddr, hwdata, r, e;
	logic [1:0] htrans;
	logic [2:0] ld, ext, presc;
	logic [15:0] ld_val, v;
	logic pinsrc;
	wire hreadyout, hresp, irq, c0_evt, step;
	wire [31:0] hrdata;
	wire [2:0] pout, poe_n, pin_in;
	wire [2:0][15:0] cnt;
	int fails, cmp_count;

	tbpc_io_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ch1_count(cnt[0]), .ch2_count(cnt[1]), .ch3_count(cnt[2]),
		.ch1_pin_b_in(pin_in[0]), .ch1_pin_b_out(pout[0]), .ch1_pin_b_oe_n(poe_n[0]),
		.ch2_pin_b_in(pin_in[1]), .ch2_pin_b_out(pout[1]), .ch2_pin_b_oe_n(poe_n[1]),
		.ch3_pin_b_in(pin_in[2]), .ch3_pin_b_out(pout[2]), .ch3_pin_b_oe_n(poe_n[2]),
		.ch0_general_reg_c_event(c0_evt), .ch4_counter_step(step),
		.ch4_prescaler_select(presc), .irq(irq));

	tbpc_far_model FAR (.hclk(hclk), .hresetn(hresetn), .run(run), .ld(ld),
		.ld_val(ld_val), .ext_lvl(ext), .c0_req(c0_req), .presc(presc), .pout(pout),
		.poe_n(poe_n), .cnt(cnt), .pin_in(pin_in), .c0_evt(c0_evt), .step(step));

	//==========================================================
	// Clock, bus tasks and helpers
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= 32'(a);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b1;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		haddr <= 32'(a);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= 1'b0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic load(input int c, input logic [15:0] val);
		ld <= 3'(1 << (c - 1));
		ld_val <= val;
		@(posedge hclk);
		ld <= 3'b000;
	endtask

	function automatic logic [7:0] ioc(input int c);
		return OFS_IOC1 + 8'(4 * (c - 1));
	endfunction

	function automatic logic [7:0] grb(input int c);
		return OFS_GRB1 + 8'(4 * (c - 1));
	endfunction

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		end_of_test();
	end

	//==========================================================
	// Main sequence
	initial begin
		hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00;
		hwrite = 1'b0; hwdata = '0; run = 1'b1; ld = '0; ld_val = '0; ext = '0;
		c0_req = 1'b0; presc = 3'h0; fails = 0; cmp_count = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("oe_n reset", 3'b111, poe_n)
		rd(OFS_GRB1, r);
		`CHK("grb reset", 32'h0000_ffff, r)
		`CHK("hresp", 1'b0, hresp)
		rd(8'h40, r);
		`CHK("unmapped", 32'h0000_0000, r)
		// Compare codes on every channel
		for (int c = 1; c <= 3; c++) begin
			for (int k = 0; k < 8; k++) begin
				wr(ioc(c), 32'(k) << 4);
				cyc(2); #1;
				`CHK("oe_n", (k[1:0] == 0), poe_n[c-1])
				if (k[1:0] != 0) begin
					`CHK("init", k[2], pout[c-1])
					wr(grb(c), 32'h0000_0100);
					load(c, 16'h00fd);
					cyc(3); #1;
					`CHK("pre", k[2], pout[c-1])
					cyc(1); #1;
					e = (k[1:0] == 1) ? 0 : (k[1:0] == 2) ? 1 : 32'(!k[2]);
					`CHK("act", e[0], pout[c-1])
				end
			end
		end
		rd(OFS_STAT, r);
		`CHK("stat cmp", 32'h0000_0007, r)
		// Interrupt raise, mask, clear
		wr(OFS_IEN, 32'h0000_0002); #1;
		`CHK("irq on", 1'b1, irq)
		wr(OFS_IEN, 32'h0000_0000); #1;
		`CHK("irq mask", 1'b0, irq)
		wr(OFS_CLR, 32'h0000_0007);
		wr(OFS_IEN, 32'h0000_0007);
		rd(OFS_STAT, r);
		`CHK("stat clr", 32'h0000_0000, r)
		`CHK("irq clr", 1'b0, irq)
		clk_en <= 1'b0;
		cyc(2); #1;
		`CHK("freeze", 1'b0, hreadyout)
		clk_en <= 1'b1;
		// Pin capture edges, bit 6 and internal codes
		run <= 1'b0;
		for (int c = 1; c <= 3; c++) begin
			for (int k = 8; k < 16; k++) begin
				pinsrc = (k < 12) || (c == 2);
				v = 16'(c * 4096 + k * 256 + 17);
				wr(ioc(c), 32'(k) << 4);
				wr(grb(c), 32'h0000_0000);
				load(c, v);
				ext[c-1] <= 1'b1;
				cyc(4);
				rd(grb(c), r);
				e = (pinsrc && k[1:0] != 1) ? 32'(v) : 32'h0000_0000;
				`CHK("rise", e, r)
				rd(OFS_PINS, r);
				`CHK("pins", 32'(1) << (PINS_IN_LSB + c - 1), r)
				load(c, v + 16'h0001);
				ext[c-1] <= 1'b0;
				cyc(4);
				rd(grb(c), r);
				if (pinsrc && k[1:0] != 0) e = 32'(v + 16'h0001);
				`CHK("fall", e, r)
			end
		end
		for (int c = 1; c <= 3; c++) begin
			v = 16'h0a00 + 16'(c);
			wr(ioc(c), 32'h0000_00c0);
			wr(grb(c), 32'h0000_0000);
			presc <= 3'(c == 3);
			load(c, v);
			c0_req <= 1'b1;
			cyc(1);
			c0_req <= 1'b0;
			cyc(8);
			rd(grb(c), r);
			`CHK("internal", (c == 2) ? 32'h0000_0000 : 32'(v), r)
		end
		presc <= 3'h0;
		load(3, v + 16'h0010);
		cyc(8);
		rd(grb(3), r);
		`CHK("undivided", 32'(v), r)
		end_of_test();
	end

endmodule

`default_nettype wire
